// ### led_strap_chk.sv
`timescale 1ns/1ns
`default_nettype none
module led_chk(
    input wire logic sys_clk_in, reset_n_in, ind_enable_in, gang_strap_en_in, boost_strap_en_in,
    input wire logic [7:1] ind_req_in,
    input wire logic [2:0] strap_pin_in, strap_pin_oe_n_out,
    input wire logic [3:0] enhanced_ind_upper_ports_n_out,
    input wire logic enhanced_ind_port3_n_out, gang_mode_out,
    input wire logic [1:0] enhanced_ind_lower_ports_n_out, drive_current_field_out
);
    // straps land two edges after release, pins driven one edge later
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence rel2;
        $rose(reset_n_in) ##1 1'b1;
    endsequence
    AST_UP: assert property (!strap_pin_oe_n_out[2] |->
        enhanced_ind_upper_ports_n_out == ~$past(ind_req_in[7:4])) else $error("upper");
    AST_P3: assert property (!strap_pin_oe_n_out[2] |->
        enhanced_ind_port3_n_out == ($past(ind_req_in[3]) ^ gang_mode_out)) else $error("p3");
    AST_LO: assert property (!strap_pin_oe_n_out[0] |->
        enhanced_ind_lower_ports_n_out == ($past(ind_req_in[2:1]) ^
        $past(drive_current_field_out))) else $error("p21");
    AST_OE: assert property (!ind_enable_in |=> &strap_pin_oe_n_out) else $error("oe");
    AST_REL: assert property (rel2 |=> &strap_pin_oe_n_out) else $error("rel");
    AST_GANG: assert property (rel2 |=> gang_mode_out ==
        (!gang_strap_en_in || $past(strap_pin_in[2]))) else $error("gang");
    AST_BST: assert property (rel2 |=> drive_current_field_out ==
        (boost_strap_en_in ? $past(strap_pin_in[1:0]) : 2'h0)) else $error("boost");
    AST_HOLD: assert property ($changed(gang_mode_out) |->
        !$past(reset_n_in, 3)) else $error("hold");
endmodule
bind led_strap_polarity_logic led_chk led_chk_inst(.*);
`default_nettype wire

// ### led_strap_defines.svh
// Function
// - drive port 4-7 indicator outputs active low once indicator support enabled
// - port 3 indicator shares gang strap pin, driven only when support enabled
// - sample port 3 pin at reset release when gang strap enabled
// - gang strap 0: per-port switching and sensing, port 3 active high
// - gang strap 1: ganged switching and sensing, port 3 active low
// - sample port 1/2 pins at reset release into drive current field
// - upper boost bit sets port 2 polarity: 1 active low, 0 high
// - lower boost bit sets port 1 polarity: 1 active low, 0 high
`ifndef LED_STRAP_DEFINES_SVH
`define LED_STRAP_DEFINES_SVH
`define UP_BOOST_OFFSET 8'hF6
`define DN_BOOST_OFFSET 8'hF8
`define BOOST_FIELD_LSB 0
`define BOOST_FIELD_W 2
`define BOOST_RESET 2'h0
`define GANG_RESET 1'h1
`endif

// ### led_strap_pkg.sv
package led_strap_pkg;
    typedef logic [1:0] drive_current_t;
    typedef enum logic [2:0] {
        ST_RESET  = 3'h1,
        ST_SAMPLE = 3'h2,
        ST_RUN    = 3'h4
    } strap_state_t;
endpackage

// ### led_strap_polarity_logic.sv
`timescale 1ns/1ns
`default_nettype none
`include "led_strap_defines.svh"
module led_strap_polarity_logic (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // configuration
    input wire logic ind_enable_in,
    input wire logic gang_strap_en_in,
    input wire logic boost_strap_en_in,
    // register access at f6h / f8h
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // per-port indicator requests, active high
    input wire logic [7:1] ind_req_in,
    // strap pin inputs: bit0 port1, bit1 port2, bit2 port3
    input wire logic [2:0] strap_pin_in,
    // indicator pins
    output logic [3:0] enhanced_ind_upper_ports_n_out,
    output logic enhanced_ind_port3_n_out,
    output logic [1:0] enhanced_ind_lower_ports_n_out,
    output logic [2:0] strap_pin_oe_n_out,
    // strap results
    output logic gang_mode_out,
    output logic [1:0] drive_current_field_out,
    output logic [7:0] up_boost_out,
    output logic [7:0] dn_boost_out
);
    // strap sequencer state
    led_strap_pkg::strap_state_t st_q;
    led_strap_pkg::strap_state_t st_d;

    // latched strap results and the two boost registers
    logic gang_q;
    logic gang_d;
    logic [7:0] up_q;
    logic [7:0] up_d;
    logic [7:0] dn_q;
    logic [7:0] dn_d;

    // registered pin drive, so every output comes from a flop
    logic [3:0] upper_q;
    logic [3:0] upper_d;
    logic port3_q;
    logic port3_d;
    logic [1:0] lower_q;
    logic [1:0] lower_d;
    logic [2:0] oe_n_q;
    logic [2:0] oe_n_d;

    // registered read data
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // strap pin levels after the two-stage synchroniser
    logic [2:0] pins_s;

    // polarity of a lit output: strap 1 drives low when lit, 0 drives high
    function automatic logic drive(input logic pol_low, input logic on);
        drive = pol_low ? ~on : on;
    endfunction

    // register select; shared by the write strobes and the read mux
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction

    // sequencer decode
    wire sample = (st_q == led_strap_pkg::ST_SAMPLE);
    wire run = (st_q == led_strap_pkg::ST_RUN);

    // register decode
    wire sel_up = hit(reg_addr_in, `UP_BOOST_OFFSET);
    wire sel_dn = hit(reg_addr_in, `DN_BOOST_OFFSET);

    // writes land only in run, so a strap sample can never race a write
    wire wr_up = run && reg_wr_in && sel_up;
    wire wr_dn = run && reg_wr_in && sel_dn;

    // strap capture strobes, one cycle wide in the sample state
    wire take_gang = sample && gang_strap_en_in;
    wire take_boost = sample && boost_strap_en_in;

    // live polarity bits: software writes to the field move port 1/2 polarity
    wire [1:0] boost_cur = up_q[`BOOST_FIELD_LSB +: `BOOST_FIELD_W];

    // lit requests gated by indicator support; unlit level when disabled
    wire [3:0] lit_upper = ind_req_in[7:4] & {4{ind_enable_in}};
    wire lit_port3 = ind_req_in[3] & ind_enable_in;
    wire [1:0] lit_lower = ind_req_in[2:1] & {2{ind_enable_in}};

    // strap pins cross from the board, so they pass two flops first
    pin_sync_if #(.W(3)) sif ();
    assign sif.raw = strap_pin_in;
    assign pins_s = sif.synced;
    pin_sync #(.W(3)) u_sync (
        .sys_clk_in(sys_clk_in),
        .bus(sif)
    );

    // reset -> one sample cycle -> run forever; sync stages fill during reset
    always_comb begin
        case (st_q)
            led_strap_pkg::ST_RESET: st_d = led_strap_pkg::ST_SAMPLE;
            led_strap_pkg::ST_SAMPLE: st_d = led_strap_pkg::ST_RUN;
            led_strap_pkg::ST_RUN: st_d = led_strap_pkg::ST_RUN;
            default: st_d = led_strap_pkg::ST_RESET;
        endcase
    end

    // gang strap is latched once; its reset level means ganged when disabled
    assign gang_d = take_gang ? pins_s[2] : gang_q;

    // boost strap fills bits 1:0 of both registers, upper bits are kept
    assign up_d = take_boost ? {up_q[7:2], pins_s[1:0]} :
                  wr_up ? reg_wdata_in : up_q;
    assign dn_d = take_boost ? {dn_q[7:2], pins_s[1:0]} :
                  wr_dn ? reg_wdata_in : dn_q;

    // pins stay inputs until the straps are latched, so the board's pulls
    // are what gets sampled; driving earlier would read back our own level
    assign oe_n_d = (run && ind_enable_in) ? 3'h0 : 3'h7;

    // ports 4-7 have no strap, so they are always active low
    assign upper_d = ~lit_upper;

    // port 3 polarity follows the latched gang strap
    assign port3_d = drive(gang_q, lit_port3);

    // ports 1 and 2 each follow their own boost bit
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_lower
            assign lower_d[g] = drive(boost_cur[g], lit_lower[g]);
        end
    endgenerate

    // unmapped reads return zero
    assign rdata_d = sel_up ? up_q : (sel_dn ? dn_q : 8'h00);

    // sequencer register
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st_q <= led_strap_pkg::ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // strap results and boost registers; the board must hold pins through reset
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            gang_q <= `GANG_RESET;
            up_q <= {6'h00, `BOOST_RESET};
            dn_q <= {6'h00, `BOOST_RESET};
        end else begin
            gang_q <= gang_d;
            up_q <= up_d;
            dn_q <= dn_d;
        end
    end

    // pin drive; every indicator rests high while in reset
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            oe_n_q <= 3'h7;
            upper_q <= 4'hF;
            port3_q <= 1'h1;
            lower_q <= 2'h3;
        end else begin
            oe_n_q <= oe_n_d;
            upper_q <= upper_d;
            port3_q <= port3_d;
            lower_q <= lower_d;
        end
    end

    // read data lags the address by one cycle
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // outputs straight from the flops

    assign enhanced_ind_upper_ports_n_out = upper_q;
    assign enhanced_ind_port3_n_out = port3_q;
    assign enhanced_ind_lower_ports_n_out = lower_q;
    assign strap_pin_oe_n_out = oe_n_q;
    assign gang_mode_out = gang_q;
    assign drive_current_field_out = up_q[1:0];
    assign up_boost_out = up_q;
    assign dn_boost_out = dn_q;
    assign reg_rdata_out = rdata_q;
endmodule
`default_nettype wire

// ### pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 3
) (
    input wire logic sys_clk_in,
    pin_sync_if.sync bus
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    // two stages; only the second is visible outside
    always_ff @(posedge sys_clk_in) begin
        meta_q <= bus.raw;
        sync_q <= meta_q;
    end
    assign bus.synced = sync_q;
endmodule
`default_nettype wire

// ### pin_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_if #(parameter int W = 3);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport sync (input raw, output synced);
    modport user (output raw, input synced);
endinterface
`default_nettype wire

// ### strap_board.sv
`timescale 1ns/1ns
`default_nettype none
module strap_board(
    input wire logic [2:0] pull_in,
    input wire logic [2:0] oe_n_in,
    input wire logic [2:0] drv_in,
    output logic [2:0] pin_out
);
    // a released pin rests at its pull level, so the strap reads stable
    assign pin_out = (oe_n_in & pull_in) | (~oe_n_in & drv_in);
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic sys_clk_in = 0, reset_n_in = 0, ind_enable_in = 1, reg_wr_in = 0;
    logic gang_strap_en_in = 0, boost_strap_en_in = 0;
    logic [7:0] reg_addr_in = 8'hF6, reg_wdata_in = 8'h5A;
    logic [7:1] ind_req_in = 7'h00;
    logic [2:0] pull = 3'h0;
    wire logic [7:0] reg_rdata_out, up_boost_out, dn_boost_out;
    wire logic [3:0] enhanced_ind_upper_ports_n_out;
    wire logic [2:0] strap_pin_in, strap_pin_oe_n_out;
    wire logic [1:0] enhanced_ind_lower_ports_n_out, drive_current_field_out;
    wire logic enhanced_ind_port3_n_out, gang_mode_out;
    wire logic [7:0] leds = {1'b0, enhanced_ind_upper_ports_n_out, enhanced_ind_port3_n_out,
        enhanced_ind_lower_ports_n_out};
    // row: gang en, boost en, pulls, expected gang, expected field
    logic [7:0] rows [5] = '{8'hC0, 8'hED, 8'hD2, 8'hFF, 8'h14};
    int n_errors = 0, n_tests = 0;
    always #10 sys_clk_in = ~sys_clk_in;
    led_strap_polarity_logic led_strap_polarity_logic_inst(.*);
    strap_board strap_board_inst(.pull_in(pull), .oe_n_in(strap_pin_oe_n_out),
        .drv_in(leds[2:0]), .pin_out(strap_pin_in));
    task automatic chk(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // each row is a fresh reset, so the straps are sampled again
    initial begin
        for (int i = 0; i < 5; i++) begin
            {gang_strap_en_in, boost_strap_en_in, pull} = rows[i][7:3];
            reset_n_in = 0;
            repeat (12) @(posedge sys_clk_in);
            #1 reset_n_in = 1;
            chk(strap_pin_oe_n_out, 8'h07);
            repeat (4) @(posedge sys_clk_in);
            #1 ind_req_in = i[0] ? 7'h55 : 7'h2A;
            chk(gang_mode_out, rows[i][2]);
            chk(drive_current_field_out, rows[i][1:0]);
            @(posedge sys_clk_in) #1 chk(leds, {1'b0, ~ind_req_in[7:4],
                ind_req_in[3:1] ^ rows[i][2:0]});
            $display("row %0d done", i);
        end
        // back-to-back writes to both boost registers, reads, unmapped write
        reg_wr_in = 1;
        @(posedge sys_clk_in) #1 reg_addr_in = 8'hF8;
        reg_wdata_in = 8'hA5;
        chk(up_boost_out, 8'h5A);
        chk(drive_current_field_out, 8'h02);
        @(posedge sys_clk_in) #1 reg_wr_in = 0;
        reg_addr_in = 8'hF6;
        chk(dn_boost_out, 8'hA5);
        @(posedge sys_clk_in) #1 reg_addr_in = 8'hF8;
        chk(reg_rdata_out, 8'h5A);
        @(posedge sys_clk_in) #1 reg_addr_in = 8'h10;
        reg_wr_in = 1;
        reg_wdata_in = 8'hFF;
        chk(reg_rdata_out, 8'hA5);
        @(posedge sys_clk_in) #1 reg_wr_in = 0;
        chk(reg_rdata_out, 8'h00);
        chk(up_boost_out, 8'h5A);
        chk(dn_boost_out, 8'hA5);
        repeat (2) @(posedge sys_clk_in);
        #1 ind_enable_in = 0;
        chk(leds[1:0], ind_req_in[2:1] ^ 2'h2);
        @(posedge sys_clk_in) #1 chk(strap_pin_oe_n_out, 8'h07);
        $display("write and disable done");
        finish_test;
    end
    initial begin
        #5000 n_errors++;
        finish_test;
    end
endmodule
`default_nettype wire
